// *** src/pco_compare.sv ***
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "pco_params.svh"

// Functional notes
// - bit 0 fires on upward target crossing
// - bit 1 fires on downward target crossing
// - bits 7, 8, 12 route to outputs
// - bit 13 routes to divider index output (bit 14 on comparator 37, whose bit 13 is the B divider)
// - bit 14 or 15 routes to open-collector index
// - targets are signed 32 bit, reset zero
module pco_compare (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pco_pkg::pco_pos_t position_i,
    output pco_pkg::pco_out_s outputs_o
);
    import pco_pkg::*;

    // ************************************************************
    // register file
    // ************************************************************
    pco_pos_t target [`PCO_NCMP];
    pco_attr_t attr [`PCO_NCMP];

    wire [13:0] word_idx = wb_adr_i[15:2];
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire wr_go = bus_req & wb_ack_o & wb_we_i;

    // ************************************************************
    // address decode
    // ************************************************************
    // which comparator a target index belongs to, -1 when none
    function automatic int tgt_sel(input logic [13:0] idx);
        unique case (idx)
            `PCO_IDX_T34: tgt_sel = 0;
            `PCO_IDX_T35: tgt_sel = 1;
            `PCO_IDX_T36: tgt_sel = 2;
            `PCO_IDX_T37: tgt_sel = 3;
            default: tgt_sel = -1;
        endcase
    endfunction : tgt_sel

    function automatic int attr_sel(input logic [13:0] idx);
        unique case (idx)
            `PCO_IDX_A34: attr_sel = 0;
            `PCO_IDX_A35: attr_sel = 1;
            `PCO_IDX_A36: attr_sel = 2;
            `PCO_IDX_A37: attr_sel = 3;
            default: attr_sel = -1;
        endcase
    endfunction : attr_sel

    // only bits that do something stick; the rest read back zero
    function automatic pco_attr_t attr_mask(input int n);
        unique case (n)
            0, 2: attr_mask = `PCO_ATTR_MASK_A;
            1: attr_mask = `PCO_ATTR_MASK_B;
            default: attr_mask = `PCO_ATTR_MASK_37;
        endcase
    endfunction : attr_mask

    // routing bits of one attribute word; comparator 37 carries an
    // extra B-phase bit, so its index and open-collector bits sit higher
    function automatic pco_out_s route_of(input int n, input pco_attr_t a);
        route_of = '0;
        route_of.sw_first = a[`PCO_B_FIRST];
        route_of.sw_second = a[`PCO_B_SECOND];
        route_of.div_a = a[`PCO_B_DIVA];
        unique case (n)
            0, 2: begin
                route_of.div_index = a[`PCO_B_IDX];
                route_of.oc_index = a[`PCO_B_OC_EVEN];
            end
            1: begin
                route_of.div_index = a[`PCO_B_IDX];
                route_of.oc_index = a[`PCO_B_OC_ODD];
            end
            default: begin
                route_of.div_b = a[`PCO_B_DIVB_37];
                route_of.div_index = a[`PCO_B_IDX_37];
                route_of.oc_index = a[`PCO_B_OC_37];
            end
        endcase
    endfunction : route_of

    // unmapped words answer with zero and drop writes
    int t_hit;
    int a_hit;
    assign t_hit = tgt_sel(word_idx);
    assign a_hit = attr_sel(word_idx);

    // ************************************************************
    // read path
    // ************************************************************
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (t_hit >= 0) begin
            rd_word = target[t_hit[1:0]];
        end else if (a_hit >= 0) begin
            rd_word = {16'h0000, attr[a_hit[1:0]]};
        end
    end

    // ************************************************************
    // bus answer
    // ************************************************************
    // a held strobe would be answered every other cycle
    // ack a cycle after the strobe and drop it the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= rd_word;
        end
    end

    // ************************************************************
    // register storage
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `PCO_NCMP; g++) begin : g_reg
            wire pco_attr_t keep = attr_mask(g);
            // a write lands on the edge that sees ack high
            // byte lanes honoured; unused attribute bits kept at zero
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    target[g] <= `PCO_TARGET_RST;
                    attr[g] <= `PCO_ATTR_RST;
                end else if (wr_go && t_hit == g) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            target[g][8*b +: 8] <= wb_dat_i[8*b +: 8];
                        end
                    end
                end else if (wr_go && a_hit == g) begin
                    for (int b = 0; b < 2; b++) begin
                        if (wb_sel_i[b]) begin
                            attr[g][8*b +: 8] <=
                                wb_dat_i[8*b +: 8] & keep[8*b +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // crossing detection
    // ************************************************************
    pco_pos_t prev_pos;
    logic prev_valid;
    logic [`PCO_NCMP-1:0] fire;
    pco_out_s next_out;
    pco_out_s route [`PCO_NCMP];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_pos <= `PCO_TARGET_RST;
            // no history yet, so the first sample cannot fire
            prev_valid <= 1'b0;
        end else begin
            prev_pos <= position_i;
            prev_valid <= 1'b1;
        end
    end

    // ************************************************************
    // per-comparator crossing
    // ************************************************************
    generate
        for (g = 0; g < `PCO_NCMP; g++) begin : g_cmp
            // a jump straight across the target counts as a crossing
            // and landing exactly on it counts as reached
            // live registers feed the compare, so writes act at once
            wire below_then = prev_pos < target[g];
            wire above_then = prev_pos > target[g];
            wire up = below_then & (position_i >= target[g]);
            wire down = above_then & (position_i <= target[g]);
            assign fire[g] = prev_valid &
                ((attr[g][`PCO_B_UP] & up) |
                 (attr[g][`PCO_B_DOWN] & down));
            assign route[g] = fire[g] ? route_of(g, attr[g]) :
                pco_out_s'('0);
        end
    endgenerate

    // ************************************************************
    // output routing
    // ************************************************************
    // routes of all comparators merge, so two may share a pin
    always_comb begin
        next_out = '0;
        for (int n = 0; n < `PCO_NCMP; n++) begin
            next_out = next_out | route[n];
        end
    end

    // ************************************************************
    // output register
    // ************************************************************
    // pins are registered so each pulse lasts one whole cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            outputs_o <= '0;
        end else begin
            outputs_o <= next_out;
        end
    end
endmodule : pco_compare

// *** src/pco_params.svh ***
`ifndef PCO_PARAMS_SVH
`define PCO_PARAMS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PCO_IDX_T34 14'h1963
`define PCO_IDX_A34 14'h1965
`define PCO_IDX_T35 14'h1966
`define PCO_IDX_A35 14'h1968
`define PCO_IDX_T36 14'h1969
`define PCO_IDX_A36 14'h196b
`define PCO_IDX_T37 14'h196c
`define PCO_IDX_A37 14'h196e

// ****************************************************************
// attribute fields
// ****************************************************************
`define PCO_B_UP 0
`define PCO_B_DOWN 1
`define PCO_B_FIRST 7
`define PCO_B_SECOND 8
`define PCO_B_DIVA 12
`define PCO_B_IDX 13
`define PCO_B_OC_EVEN 14
`define PCO_B_OC_ODD 15
`define PCO_B_DIVB_37 13
`define PCO_B_IDX_37 14
`define PCO_B_OC_37 15
`define PCO_ATTR_MASK_A 16'h7183
`define PCO_ATTR_MASK_B 16'hb183
`define PCO_ATTR_MASK_37 16'hf183

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define PCO_TARGET_RST 32'h0000_0000
`define PCO_ATTR_RST 16'h0000
`define PCO_NCMP 4

`endif

// *** src/pco_pkg.sv ***
package pco_pkg;
    typedef logic signed [31:0] pco_pos_t;
    typedef logic [15:0] pco_attr_t;

    typedef struct packed {
        logic sw_first;
        logic sw_second;
        logic div_a;
        logic div_b;
        logic div_index;
        logic oc_index;
    } pco_out_s;
endpackage : pco_pkg

// *** sim/pco_sink.sv ***
`timescale 1ns/100ps
module pco_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pco_pkg::pco_out_s pins_i,
    output logic [7:0] hits_o
);
    import pco_pkg::*;
    // pins only listen; tally every pulse so none slips by
    always_ff @(posedge clk_i) begin
        hits_o <= rst_i ? 8'h00 : hits_o + 8'($countones(pins_i));
    end
endmodule : pco_sink

// *** sim/pco_compare_checker.sv ***
`timescale 1ns/100ps
module pco_compare_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire pco_pkg::pco_pos_t position_i,
    input wire pco_pkg::pco_out_s outputs_o
);
    import pco_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not answered");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    a_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack while bus idle");
    a_rst_quiet: assert property ($past(rst_i) |-> outputs_o == '0)
        else $error("pins active after reset");
    a_fire_moved: assert property (outputs_o != '0
        |-> $past(position_i) != $past(position_i, 2))
        else $error("pin fired without motion");
    cover property (outputs_o.sw_first);
    cover property (outputs_o.oc_index);
    cover property (wb_ack_o && wb_cyc_i);
    cover property (outputs_o.div_b);
endmodule : pco_compare_checker

bind pco_compare pco_compare_checker pco_compare_checker_inst (.clk_i,
    .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .position_i, .outputs_o);

// *** sim/position_compare_output_bench.sv ***
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module position_compare_output_bench;
    import pco_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [15:0] wb_adr_i, ta;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q, t;
    pco_pos_t position_i, p0;
    pco_out_s outputs_o;
    logic [7:0] hits;
    int n_errors, samples_checked, cycles;
    int rb[10] = '{7, 8, 12, 13, 14, 15, 14, 13, 14, 15};
    int rc[10] = '{0, 0, 0, 0, 0, 1, 2, 3, 3, 3};
    logic [15:0] tbase[4] = '{16'h658c, 16'h6598, 16'h65a4, 16'h65b0};
    logic [15:0] adrs[9] = '{16'h658c, 16'h6594, 16'h6598, 16'h65a0,
        16'h65a4, 16'h65ac, 16'h65b0, 16'h65b8, 16'h0100};
    pco_compare pco_compare_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .position_i, .outputs_o);
    pco_sink pco_sink_inst (.clk_i, .rst_i, .pins_i(outputs_o),
        .hits_o(hits));
    function automatic pco_out_s pin(input int c, input int b);
        case (b)
            7: pin = 6'h20;
            8: pin = 6'h10;
            12: pin = 6'h08;
            13: pin = (c == 3) ? 6'h04 : 6'h02;
            14: pin = (c == 3) ? 6'h02 : 6'h01;
            default: pin = 6'h01;
        endcase
    endfunction : pin
    task automatic wb(input logic w, input logic [15:0] a,
        input logic [31:0] d, output logic [31:0] r);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    task automatic mv(input pco_pos_t p, input pco_out_s e);
        position_i <= p;
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK("pins", e, outputs_o)
        @(posedge clk_i);
    endtask : mv
    task give_verdict;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        clk_i = 0;
        forever #4 clk_i = ~clk_i;
    end
    // hang guard: whole sequence needs a few hundred cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cycles} = '0;
        rst_i = 1;
        {wb_adr_i, wb_dat_i, position_i} = '0;
        wb_sel_i = 4'hf;
        void'($urandom(54));
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        foreach (adrs[i]) begin
            wb(0, adrs[i], 32'h0, q);
            `CHK("reset", 32'h0, q)
        end
        wb(1, 16'h6594, 32'hffff, q);
        wb(0, 16'h6594, 32'h0, q);
        `CHK("mask34", 32'h7183, q)
        wb(1, 16'h6594, 32'h0, q);
        wb(1, 16'h65a0, 32'hffff, q);
        wb(0, 16'h65a0, 32'h0, q);
        `CHK("mask35", 32'hb183, q)
        wb(1, 16'h65a0, 32'h0, q);
        t = $urandom;
        wb(1, 16'h65a4, t, q);
        wb(0, 16'h65a4, 32'h0, q);
        `CHK("target36", t, q)
        foreach (rb[i]) begin
            p0 = $signed($urandom) >>> 2;
            ta = tbase[rc[i]];
            wb(1, ta, p0, q);
            wb(1, ta + 16'h8, 32'h1 | (32'h1 << rb[i]), q);
            mv(p0 - 3, 6'h00);
            mv(p0, pin(rc[i], rb[i]));
            mv(p0 - 7, 6'h00);
            wb(1, ta + 16'h8, 32'h2 | (32'h1 << rb[i]), q);
            mv(p0 + 4, 6'h00);
            mv(p0, pin(rc[i], rb[i]));
            wb(1, ta + 16'h8, 32'h0, q);
        end
        `CHK("pulses", 8'd20, hits)
        give_verdict;
    end
endmodule : position_compare_output_bench
